// file: rtl/hsc_hot_swap_ctrl.sv
// hot-swap control and status register block with AXI4-Lite access
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module hsc_hot_swap_ctrl
    import hsc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    // AXI4-Lite slave
    input wire logic [HSC_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [HSC_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [HSC_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [HSC_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // bridge-internal status, same clock
    input wire logic preload_done_in,
    input wire logic sec_clk_ctrl_loaded_in,
    // board pins
    input wire logic ejector_switch_in,
    output logic hotswap_enumeration_out_n,
    output logic hotswap_enumeration_oe,
    output logic status_lamp_out,
    output logic irq_out
);
    // ---------------------------------------------------------------
    // address decode helper
    // ---------------------------------------------------------------
    function automatic logic [2:0] hsc_decode(input logic [HSC_AW-1:0] addr);
        logic [HSC_AW-1:0] word;
        word = {addr[HSC_AW-1:2], 2'h0};
        hsc_decode = {word == HSC_IRQ_MASK_ADDR,
                      word == HSC_IRQ_STAT_ADDR,
                      word == HSC_CSR_ADDR};
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic reset_done_r;
    logic [HSC_SYNC_SETTLE-1:0] settle_r;
    logic switch_level;
    logic switch_prev_r;
    logic insert_cond_prev_r;
    logic added_r;
    logic added_nxt;
    logic removal_r;
    logic removal_nxt;
    logic lamp_bit_r;
    logic lamp_bit_nxt;
    logic enum_mask_r;
    logic enum_mask_nxt;
    hsc_lamp_state_t lamp_state_r;
    hsc_lamp_state_t lamp_state_nxt;
    logic lamp_out_r;
    logic enum_active_r;
    logic [HSC_IRQ_W-1:0] irq_stat_r;
    logic [HSC_IRQ_W-1:0] irq_stat_nxt;
    logic [HSC_IRQ_W-1:0] irq_mask_r;
    logic [HSC_IRQ_W-1:0] irq_mask_nxt;
    logic irq_r;

    logic aw_hold_r;
    logic [HSC_AW-1:0] awaddr_r;
    logic w_hold_r;
    logic [HSC_DW-1:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [HSC_DW-1:0] rdata_r;
    logic [1:0] rresp_r;

    // ---------------------------------------------------------------
    // ejector switch pin
    // ---------------------------------------------------------------
    hsc_pin_sync u_switch_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pin_in(ejector_switch_in),
        .level_out(switch_level)
    );

    // ---------------------------------------------------------------
    // reset settling
    // ---------------------------------------------------------------
    // the synchroniser resets low, so its level is not trusted until it
    // has filled: a handle held open through reset would look closed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            settle_r <= '0;
        end else begin
            settle_r <= {settle_r[HSC_SYNC_SETTLE-2:0], 1'b1};
        end
    end

    // ---------------------------------------------------------------
    // bus handshake decode
    // ---------------------------------------------------------------
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_hold_r && w_hold_r && !bvalid_r;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire [2:0] wr_sel = hsc_decode(awaddr_r);
    wire [2:0] rd_sel = hsc_decode(s_axi_araddr);
    // only byte lane 0 carries live bits
    wire wr_csr = do_write && wr_sel[0] && wstrb_r[0];
    wire wr_mask = do_write && wr_sel[2] && wstrb_r[0];
    wire wr_hit = |wr_sel;
    wire rd_hit = |rd_sel;
    wire rd_stat = ar_take && rd_sel[1];
    wire [1:0] wr_resp = wr_hit ? HSC_RESP_OKAY : HSC_RESP_SLVERR;
    wire [1:0] rd_resp = rd_hit ? HSC_RESP_OKAY : HSC_RESP_SLVERR;

    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready = !w_hold_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ---------------------------------------------------------------
    // flag events
    // ---------------------------------------------------------------
    // insertion fires on the rising edge of the condition so a software
    // clear is not undone on the next cycle while the board stays seated
    wire insert_cond = reset_done_r && preload_done_in && !switch_level && !removal_r;
    wire set_added = insert_cond && !insert_cond_prev_r;
    wire switch_rise = switch_level && !switch_prev_r;
    wire set_removal = switch_rise && !added_r && reset_done_r;
    wire clr_added = wr_csr && wdata_r[HSC_BIT_ADDED];
    wire clr_removal = wr_csr && wdata_r[HSC_BIT_REMOVAL];

    // hardware set wins over a simultaneous software clear
    assign added_nxt = set_added || (added_r && !clr_added);
    assign removal_nxt = set_removal || (removal_r && !clr_removal);
    assign lamp_bit_nxt = wr_csr ? wdata_r[HSC_BIT_LAMP] : lamp_bit_r;
    assign enum_mask_nxt = wr_csr ? wdata_r[HSC_BIT_MASK] : enum_mask_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reset_done_r <= 1'b0;
            switch_prev_r <= 1'b0;
            insert_cond_prev_r <= 1'b0;
        end else begin
            reset_done_r <= settle_r[HSC_SYNC_SETTLE-1];
            switch_prev_r <= switch_level;
            insert_cond_prev_r <= insert_cond;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            added_r <= HSC_CSR_RESET[HSC_BIT_ADDED];
            removal_r <= HSC_CSR_RESET[HSC_BIT_REMOVAL];
            lamp_bit_r <= HSC_CSR_RESET[HSC_BIT_LAMP];
            enum_mask_r <= HSC_CSR_RESET[HSC_BIT_MASK];
        end else begin
            added_r <= added_nxt;
            removal_r <= removal_nxt;
            lamp_bit_r <= lamp_bit_nxt;
            enum_mask_r <= enum_mask_nxt;
        end
    end

    // ---------------------------------------------------------------
    // lamp ownership
    // ---------------------------------------------------------------
    // release is one-way until the next reset; reopening the handle later
    // leaves the lamp with software
    wire lamp_release = reset_done_r && sec_clk_ctrl_loaded_in && !switch_level;

    always_comb begin
        lamp_state_nxt = lamp_state_r;
        unique case (lamp_state_r)
            HSC_LAMP_FORCED: begin
                if (lamp_release) begin
                    lamp_state_nxt = HSC_LAMP_SOFT;
                end
            end
            HSC_LAMP_SOFT: begin
                lamp_state_nxt = HSC_LAMP_SOFT;
            end
        endcase
    end

    wire lamp_value = (lamp_state_r == HSC_LAMP_FORCED) ? 1'b1 : lamp_bit_r;

    // ---------------------------------------------------------------
    // pin drivers
    // ---------------------------------------------------------------
    wire enum_request = (added_r || removal_r) && !enum_mask_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lamp_state_r <= HSC_LAMP_FORCED;
            lamp_out_r <= 1'b1;
            enum_active_r <= 1'b0;
        end else begin
            lamp_state_r <= lamp_state_nxt;
            lamp_out_r <= lamp_value;
            enum_active_r <= enum_request;
        end
    end

    assign status_lamp_out = lamp_out_r;
    // open-drain: only ever pulls low, and only while enabled
    assign hotswap_enumeration_out_n = 1'b0;
    assign hotswap_enumeration_oe = enum_active_r;

    // ---------------------------------------------------------------
    // interrupt status and mask
    // ---------------------------------------------------------------
    wire [HSC_IRQ_W-1:0] irq_events = {set_removal, set_added};

    // read clears, but an event in the same cycle survives
    assign irq_stat_nxt = irq_events | (rd_stat ? '0 : irq_stat_r);
    assign irq_mask_nxt = wr_mask ? wdata_r[HSC_IRQ_W-1:0] : irq_mask_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
        end
    end

    // registered from the next-state terms so the pin tracks the status
    // and mask registers in the same cycle rather than one behind
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_nxt & irq_mask_nxt);
        end
    end

    assign irq_out = irq_r;

    // ---------------------------------------------------------------
    // write channel
    // ---------------------------------------------------------------
    // address and data arrive in either order; the write fires once both are held
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_hold_r <= 1'b0;
            awaddr_r <= '0;
        end else if (aw_take) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (do_write) begin
            aw_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            w_hold_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (w_take) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (do_write) begin
            w_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bvalid_r <= 1'b0;
            bresp_r <= HSC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_resp;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // read channel
    // ---------------------------------------------------------------
    logic [HSC_REG_W-1:0] csr_view;
    always_comb begin
        csr_view = '0;
        csr_view[HSC_BIT_ADDED] = added_r;
        csr_view[HSC_BIT_REMOVAL] = removal_r;
        csr_view[HSC_BIT_LAMP] = lamp_bit_r;
        csr_view[HSC_BIT_MASK] = enum_mask_r;
    end

    wire [HSC_DW-1:0] csr_word = {{(HSC_DW-HSC_REG_W){1'b0}}, csr_view};
    wire [HSC_DW-1:0] stat_word = {{(HSC_DW-HSC_IRQ_W){1'b0}}, irq_stat_r};
    wire [HSC_DW-1:0] mask_word = {{(HSC_DW-HSC_IRQ_W){1'b0}}, irq_mask_r};
    wire [HSC_DW-1:0] rd_value =
        rd_sel[0] ? csr_word :
        rd_sel[1] ? stat_word :
        rd_sel[2] ? mask_word : '0;

    // arready stays low while a response waits, so one read at a time

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= HSC_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_value;
            rresp_r <= rd_resp;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
endmodule

// file: rtl/hsc_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module hsc_pin_sync (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic pin_in,
    output logic level_out
);
    logic stage1_r;
    logic stage2_r;
    logic stage3_r;
    logic level_r;

    // stage1 feeds only stage2; the filter looks at stages 2 and 3
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_r <= 1'b0;
            stage2_r <= 1'b0;
            stage3_r <= 1'b0;
        end else begin
            stage1_r <= pin_in;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            level_r <= 1'b0;
        end else if (stage2_r == stage3_r) begin
            level_r <= stage3_r;
        end
    end

    assign level_out = level_r;
endmodule

// file: rtl/hsc_pkg.sv
// constants shared by the hot-swap control and status block
package hsc_pkg;
    // ---------------------------------------------------------------
    // bus geometry
    // ---------------------------------------------------------------
    localparam int HSC_AW = 12;
    localparam int HSC_DW = 32;
    localparam int HSC_REG_W = 16;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    // printed index of the control/status register; byte address is four times it
    localparam logic [HSC_AW-1:0] HSC_CSR_INDEX = 12'h0E6;
    localparam logic [HSC_AW-1:0] HSC_CSR_ADDR = 12'h398;
    localparam logic [HSC_AW-1:0] HSC_IRQ_STAT_ADDR = 12'h000;
    localparam logic [HSC_AW-1:0] HSC_IRQ_MASK_ADDR = 12'h004;
    localparam logic [HSC_REG_W-1:0] HSC_CSR_RESET = 16'h0000;

    // ---------------------------------------------------------------
    // control/status field positions
    // ---------------------------------------------------------------
    localparam int HSC_BIT_ADDED = 7;
    localparam int HSC_BIT_REMOVAL = 6;
    localparam int HSC_BIT_LAMP = 3;
    localparam int HSC_BIT_MASK = 1;

    // ---------------------------------------------------------------
    // interrupt status / mask layout
    // ---------------------------------------------------------------
    localparam int HSC_IRQ_W = 2;
    localparam int HSC_IRQ_ADDED = 0;
    localparam int HSC_IRQ_REMOVAL = 1;

    // ---------------------------------------------------------------
    // pin synchroniser fill time, in clock edges
    // ---------------------------------------------------------------
    localparam int HSC_SYNC_SETTLE = 4;

    // ---------------------------------------------------------------
    // bus responses
    // ---------------------------------------------------------------
    localparam logic [1:0] HSC_RESP_OKAY = 2'h0;
    localparam logic [1:0] HSC_RESP_SLVERR = 2'h2;

    // ---------------------------------------------------------------
    // lamp ownership
    // ---------------------------------------------------------------
    typedef enum logic [0:0] {
        HSC_LAMP_FORCED = 1'h0,
        HSC_LAMP_SOFT = 1'h1
    } hsc_lamp_state_t;
endpackage

// file: sim/hsc_board_model.sv
// board-side model: ejector handle, pulled-up enumeration line, lamp
`timescale 1ns/1ps
module hsc_board_model (
    input wire logic handle_open,
    input wire logic hotswap_enumeration_out_n,
    input wire logic hotswap_enumeration_oe,
    input wire logic status_lamp_out,
    output logic ejector_switch_in,
    output logic enum_wire,
    output logic lamp_lit
);
    // contact closes to high while the handle is open
    assign ejector_switch_in = handle_open;
    // host pull-up: a released line reads high, never the last driven value
    assign enum_wire = hotswap_enumeration_oe ? hotswap_enumeration_out_n : 1'b1;
    assign lamp_lit = status_lamp_out;
endmodule

// file: sim/hsc_hot_swap_monitor.sv
// assertion checker for the hot-swap control and status block
`timescale 1ns/1ps
module hsc_hot_swap_monitor
    import hsc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [HSC_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [HSC_DW-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sec_clk_ctrl_loaded_in,
    input wire logic hotswap_enumeration_out_n,
    input wire logic hotswap_enumeration_oe,
    input wire logic status_lamp_out
);
    logic loaded_seen_r;
    logic [HSC_AW-1:0] rd_addr_r;
    logic mapped;
    assign mapped = (s_axi_araddr == HSC_CSR_ADDR) || (s_axi_araddr == HSC_IRQ_STAT_ADDR)
        || (s_axi_araddr == HSC_IRQ_MASK_ADDR);
    // lamp may only leave forced-on once the clock control load has been seen
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            loaded_seen_r <= 1'b0;
            rd_addr_r <= '0;
        end else begin
            loaded_seen_r <= loaded_seen_r | sec_clk_ctrl_loaded_in;
            rd_addr_r <= (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rd_addr_r;
        end
    end
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_lamp_forced;
        !loaded_seen_r |-> status_lamp_out;
    endproperty
    property p_enum_od;
        hotswap_enumeration_out_n == 1'b0;
    endproperty
    property p_csr_zero_bits;
        s_axi_rvalid && (rd_addr_r == HSC_CSR_ADDR) |-> (s_axi_rdata & 32'hFFFF_FF35) == '0;
    endproperty
    property p_wr_latency;
        s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    property p_rd_latency;
        s_rd_taken |=> s_axi_rvalid;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_busy_refuse;
        (s_axi_rvalid |-> !s_axi_arready) and (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready);
    endproperty
    // first cycle of a read: data and pin show the same register snapshot
    property p_enum_follows;
        $rose(s_axi_rvalid) && (rd_addr_r == HSC_CSR_ADDR) |-> hotswap_enumeration_oe ==
            ((s_axi_rdata[HSC_BIT_ADDED] || s_axi_rdata[HSC_BIT_REMOVAL])
            && !s_axi_rdata[HSC_BIT_MASK]);
    endproperty
    property p_unmapped_rd;
        s_rd_taken ##0 !mapped |=> s_axi_rresp == HSC_RESP_SLVERR && s_axi_rdata == '0;
    endproperty
    a_lamp_forced: assert property (p_lamp_forced) else $error("lamp left on-state early");
    a_enum_od: assert property (p_enum_od) else $error("enumeration data not low");
    a_csr_zero_bits: assert property (p_csr_zero_bits) else $error("unused bits set");
    a_wr_latency: assert property (p_wr_latency) else $error("write response timing wrong");
    a_rd_latency: assert property (p_rd_latency) else $error("read data late");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    a_busy_refuse: assert property (p_busy_refuse) else $error("ready while response pending");
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not refused");
    a_enum_follows: assert property (p_enum_follows) else $error("enum pin vs flags");
endmodule

bind hsc_hot_swap_ctrl hsc_hot_swap_monitor u_mon (
    .clk(clk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sec_clk_ctrl_loaded_in(sec_clk_ctrl_loaded_in),
    .hotswap_enumeration_out_n(hotswap_enumeration_out_n),
    .hotswap_enumeration_oe(hotswap_enumeration_oe),
    .status_lamp_out(status_lamp_out)
);

// file: sim/test_hsc_hot_swap_ctrl.sv
// self-checking bench for the hot-swap control and status block
`timescale 1ns/1ps
module test_hsc_hot_swap_ctrl
    import hsc_pkg::*;
;
    logic clk, reset_n, awvalid, wvalid, bready, arvalid, rready;
    logic [HSC_AW-1:0] awaddr, araddr;
    logic [HSC_DW-1:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, preload, sec_loaded, handle_open;
    logic sw, enum_n, enum_oe, lamp, irq, enum_wire, lamp_lit;
    int errors = 0;
    int cmp_count = 0;
    hsc_hot_swap_ctrl dut (
        .clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .preload_done_in(preload), .sec_clk_ctrl_loaded_in(sec_loaded),
        .ejector_switch_in(sw), .hotswap_enumeration_out_n(enum_n),
        .hotswap_enumeration_oe(enum_oe), .status_lamp_out(lamp), .irq_out(irq)
    );
    hsc_board_model board (
        .handle_open(handle_open), .hotswap_enumeration_out_n(enum_n),
        .hotswap_enumeration_oe(enum_oe), .status_lamp_out(lamp),
        .ejector_switch_in(sw), .enum_wire(enum_wire), .lamp_lit(lamp_lit)
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [HSC_AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        bready <= 1'b0;
        chk(32'(bvalid), 32'h1);
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [HSC_AW-1:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        rready <= 1'b0;
        chk(32'(rvalid), 32'h1);
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
    endtask
    task automatic end_of_test;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // the whole sequence needs well under 2000 cycles
    initial begin
        #200000;
        errors++;
        end_of_test;
    end
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        {reset_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {preload, sec_loaded, handle_open} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hF;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        rd(HSC_CSR_ADDR, 32'h0, HSC_RESP_OKAY);
        chk(32'(lamp_lit), 32'h1);
        wr(HSC_CSR_ADDR, 32'h35, HSC_RESP_OKAY);
        rd(HSC_CSR_ADDR, 32'h0, HSC_RESP_OKAY);
        chk(32'(lamp_lit), 32'h1);
        sec_loaded <= 1'b1;
        repeat (10) @(posedge clk);
        chk(32'(lamp_lit), 32'h0);
        wr(HSC_CSR_ADDR, 32'h08, HSC_RESP_OKAY);
        repeat (3) @(posedge clk);
        chk(32'(lamp_lit), 32'h1);
        wr(HSC_CSR_ADDR, 32'hC8, HSC_RESP_OKAY);
        rd(HSC_CSR_ADDR, 32'h08, HSC_RESP_OKAY);
        wr(HSC_IRQ_MASK_ADDR, 32'h3, HSC_RESP_OKAY);
        rd(HSC_IRQ_MASK_ADDR, 32'h3, HSC_RESP_OKAY);
        preload <= 1'b1;
        repeat (10) @(posedge clk);
        rd(HSC_CSR_ADDR, 32'h88, HSC_RESP_OKAY);
        chk(32'(enum_wire), 32'h0);
        chk(32'(irq), 32'h1);
        rd(HSC_IRQ_STAT_ADDR, 32'h1, HSC_RESP_OKAY);
        chk(32'(irq), 32'h0);
        rd(HSC_IRQ_STAT_ADDR, 32'h0, HSC_RESP_OKAY);
        wr(HSC_CSR_ADDR, 32'h0A, HSC_RESP_OKAY);
        repeat (3) @(posedge clk);
        chk(32'(enum_wire), 32'h1);
        rd(HSC_CSR_ADDR, 32'h8A, HSC_RESP_OKAY);
        wr(HSC_CSR_ADDR, 32'h88, HSC_RESP_OKAY);
        repeat (3) @(posedge clk);
        rd(HSC_CSR_ADDR, 32'h08, HSC_RESP_OKAY);
        chk(32'(enum_wire), 32'h1);
        wr(HSC_IRQ_MASK_ADDR, 32'h0, HSC_RESP_OKAY);
        handle_open <= 1'b1;
        repeat (10) @(posedge clk);
        rd(HSC_CSR_ADDR, 32'h48, HSC_RESP_OKAY);
        chk(32'(enum_wire), 32'h0);
        chk(32'(irq), 32'h0);
        rd(HSC_IRQ_STAT_ADDR, 32'h2, HSC_RESP_OKAY);
        wr(HSC_CSR_ADDR, 32'h4A, HSC_RESP_OKAY);
        repeat (3) @(posedge clk);
        rd(HSC_CSR_ADDR, 32'h0A, HSC_RESP_OKAY);
        chk(32'(enum_wire), 32'h1);
        wr(12'h100, 32'h8, HSC_RESP_SLVERR);
        rd(12'h100, 32'h0, HSC_RESP_SLVERR);
        // reset again with the handle still open: lamp must stay forced on
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (10) @(posedge clk);
        chk(32'(lamp_lit), 32'h1);
        rd(HSC_CSR_ADDR, 32'h0, HSC_RESP_OKAY);
        handle_open <= 1'b0;
        repeat (10) @(posedge clk);
        chk(32'(lamp_lit), 32'h0);
        chk(32'(enum_wire), 32'h0);
        rd(HSC_CSR_ADDR, 32'h80, HSC_RESP_OKAY);
        end_of_test;
    end
endmodule
